// [core/gauge_pkg.sv]
// Shared constants and types of the gauge status readback block.
// Assumes one core clock; the serial pins arrive asynchronously.
package gauge_pkg;

    localparam int WORD_W = 16;
    localparam int SEL_W = 4;
    localparam int SUM_W = 15;
    localparam int SAMPLE_W = 8;
    localparam int CNT_W = 16;
    localparam int SYNC_STAGES = 2;

    // Command address sits in the top bits of a received word
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 13;
    localparam logic [2:0] ADDR_ENABLE_CONFIG = 3'h0;

    // Status select field inside the enable/config command
    localparam int SEL_MSB = 11;
    localparam int SEL_LSB = 8;
    localparam int SEL_HI_BIT = 3;
    localparam int SEL_MID_BIT = 2;

    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [14:0] SUM_RESET = 15'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // Per gauge signals from the motion and drive logic
    typedef struct packed {
        logic zero_end;
        logic off_target;
        logic pos_step;
        logic overheat;
        logic reenable;
        logic homing_start;
        logic homing_stop;
    } gauge_in_type;

    // Serial pins as they enter the synchroniser
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } spi_pins_type;

    // Device status word, most significant field first
    typedef struct packed {
        logic dir_g1;
        logic dir_g0;
        logic [1:0] zero_end;
        logic [1:0] off_target;
        logic supply_high_flag;
        logic supply_low_flag;
        logic clk_trim_fault;
        logic supply_excursion_flag;
        logic [1:0] position_changed;
        logic [1:0] homing_active;
        logic [1:0] thermal_trip;
    } dev_word_type;

    // Homing sum status word
    typedef struct packed {
        logic homing_active;
        logic [14:0] homing_sum;
    } sum_word_type;

endpackage

// [core/pin_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are slow compared with the clock.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_r <= RESET_VAL;
            pin_out <= RESET_VAL;
        end else begin
            meta_r <= pin_in;
            pin_out <= meta_r;
        end
    end

endmodule

// [core/gauge_status_readback.sv]
// Status readback of a dual gauge driver: fault and event flags,
// homing sum, and the serial shifter that reports them.
// Assumes motion, drive and back-EMF logic share ref_clk; the serial
// pins are asynchronous and sampled here.
`timescale 1ns/1ps
module gauge_status_readback #(
    parameter int SAMPLE_W = gauge_pkg::SAMPLE_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic supply_over,
    input wire logic supply_under,
    input wire logic clk_trim_bad,
    input wire gauge_pkg::gauge_in_type [1:0] gauge_in,
    input wire logic bemf_valid,
    input wire logic bemf_gauge,
    input wire logic signed [SAMPLE_W-1:0] bemf_sample,
    output logic [1:0] coil_disable,
    output logic [gauge_pkg::SEL_W-1:0] status_select,
    output logic [1:0] homing_active,
    output logic [gauge_pkg::SUM_W-1:0] homing_sum
);

    gauge_pkg::spi_pins_type pins_raw;
    gauge_pkg::spi_pins_type pins_s;
    logic cs_prev_r;
    logic sclk_prev_r;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic in_frame_r;
    logic [15:0] shift_r;
    logic [15:0] rx_r;
    logic [15:0] bit_cnt_r;
    logic msg_valid;
    logic dev_sel;
    logic sum_sel;
    logic dev_read_r;
    logic dev_clear;
    logic supply_high_r;
    logic supply_low_r;
    logic excursion_r;
    logic clk_trim_r;
    logic [1:0] moved_r;
    logic [1:0] thermal_r;
    logic [1:0] zero_seen_r;
    logic [1:0] homing_stop;
    logic [1:0] homing_start;
    logic [1:0] step;
    logic [1:0] hot;
    logic [1:0] reen;
    logic signed [gauge_pkg::SUM_W-1:0] sum_nxt;
    gauge_pkg::dev_word_type dev_word;
    gauge_pkg::sum_word_type sum_word;
    logic [15:0] load_word;

    assign pins_raw = '{cs_n: cs_n, sclk: sclk, mosi: mosi};

    pin_sync #(
        .WIDTH(3),
        .RESET_VAL(3'b100)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(pins_raw),
        .pin_out(pins_s)
    );

    always_comb begin
        for (int g = 0; g < 2; g++) begin
            homing_stop[g] = gauge_in[g].homing_stop;
            homing_start[g] = gauge_in[g].homing_start;
            step[g] = gauge_in[g].pos_step;
            hot[g] = gauge_in[g].overheat;
            reen[g] = gauge_in[g].reenable;
        end
    end

    // Edge detection on synchronised pins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cs_prev_r <= 1'b1;
            sclk_prev_r <= 1'b0;
        end else begin
            cs_prev_r <= pins_s.cs_n;
            sclk_prev_r <= pins_s.sclk;
        end
    end

    assign cs_fall = cs_prev_r & ~pins_s.cs_n;
    assign cs_rise = ~cs_prev_r & pins_s.cs_n;
    assign sclk_rise = in_frame_r & ~sclk_prev_r & pins_s.sclk;
    assign sclk_fall = in_frame_r & sclk_prev_r & ~pins_s.sclk;
    assign msg_valid = cs_rise & (bit_cnt_r != gauge_pkg::CNT_RESET)
        & (bit_cnt_r[3:0] == 4'h0);

    // Word selection from the stored select field
    assign dev_sel = ~status_select[gauge_pkg::SEL_HI_BIT];
    assign sum_sel = status_select[gauge_pkg::SEL_HI_BIT]
        & ~status_select[gauge_pkg::SEL_MID_BIT];

    always_comb begin
        dev_word.dir_g1 = 1'b0;
        dev_word.dir_g0 = 1'b0;
        dev_word.zero_end = {gauge_in[1].zero_end,
            gauge_in[0].zero_end};
        dev_word.off_target = {gauge_in[1].off_target,
            gauge_in[0].off_target};
        dev_word.supply_high_flag = supply_high_r;
        dev_word.supply_low_flag = supply_low_r;
        dev_word.clk_trim_fault = clk_trim_r;
        dev_word.supply_excursion_flag = excursion_r;
        dev_word.position_changed = moved_r;
        dev_word.homing_active = homing_active;
        dev_word.thermal_trip = thermal_r;
        sum_word.homing_active = |homing_active;
        sum_word.homing_sum = homing_sum;
        if (dev_sel) begin
            load_word = dev_word;
        end else if (sum_sel) begin
            load_word = sum_word;
        end else begin
            load_word = gauge_pkg::WORD_RESET;
        end
    end

    // Serial shifter: load on select, MSB first, input fills LSB
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            in_frame_r <= 1'b0;
            shift_r <= gauge_pkg::WORD_RESET;
            bit_cnt_r <= gauge_pkg::CNT_RESET;
            miso <= 1'b0;
            miso_oe <= 1'b0;
            dev_read_r <= 1'b0;
        end else if (cs_fall) begin
            in_frame_r <= 1'b1;
            shift_r <= load_word;
            bit_cnt_r <= gauge_pkg::CNT_RESET;
            miso <= load_word[15];
            miso_oe <= 1'b1;
            dev_read_r <= dev_sel;
        end else if (cs_rise) begin
            in_frame_r <= 1'b0;
            miso_oe <= 1'b0;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[14:0], pins_s.mosi};
            bit_cnt_r <= bit_cnt_r + 16'h0001;
        end else if (sclk_fall) begin
            miso <= shift_r[15];
        end
    end

    // Last 16 received bits form the command word
    assign rx_r = shift_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_select <= gauge_pkg::SEL_RESET;
        end else if (msg_valid && rx_r[gauge_pkg::ADDR_MSB:gauge_pkg::ADDR_LSB]
                == gauge_pkg::ADDR_ENABLE_CONFIG) begin
            status_select <= rx_r[gauge_pkg::SEL_MSB:gauge_pkg::SEL_LSB];
        end
    end

    assign dev_clear = msg_valid & dev_read_r;

    // Supply fault flags: set wins over the read clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            supply_high_r <= 1'b0;
            supply_low_r <= 1'b0;
            excursion_r <= 1'b0;
        end else begin
            supply_high_r <= supply_over
                | (supply_high_r & ~dev_clear);
            supply_low_r <= supply_under
                | (supply_low_r & ~dev_clear);
            excursion_r <= supply_over | supply_under
                | (excursion_r & ~dev_clear);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clk_trim_r <= 1'b0;
        end else begin
            clk_trim_r <= clk_trim_bad;
        end
    end

    // Movement since last valid message
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            moved_r <= 2'b00;
        end else begin
            moved_r <= step | (moved_r & {2{~msg_valid}});
        end
    end

    // Thermal trip and coil disable per gauge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            thermal_r <= 2'b00;
            coil_disable <= 2'b00;
        end else begin
            thermal_r <= hot | (thermal_r & ~reen);
            coil_disable <= hot | {2{supply_over}}
                | (coil_disable & ~reen);
        end
    end

    // Homing flags: clear on stop or the message after zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            homing_active <= 2'b00;
            zero_seen_r <= 2'b00;
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (homing_start[g]) begin
                    homing_active[g] <= 1'b1;
                    zero_seen_r[g] <= 1'b0;
                end else if (homing_stop[g]) begin
                    homing_active[g] <= 1'b0;
                    zero_seen_r[g] <= 1'b0;
                end else if (zero_seen_r[g] && msg_valid) begin
                    homing_active[g] <= 1'b0;
                    zero_seen_r[g] <= 1'b0;
                end else if (homing_active[g] && bemf_gauge == g[0]
                        && homing_sum[gauge_pkg::SUM_W-1]) begin
                    zero_seen_r[g] <= 1'b1;
                end
            end
        end
    end

    // Back-EMF integrator, signed, kept after homing stops
    assign sum_nxt = $signed(homing_sum) + gauge_pkg::SUM_W'(bemf_sample);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            homing_sum <= gauge_pkg::SUM_RESET;
        end else if (|homing_start) begin
            homing_sum <= gauge_pkg::SUM_RESET;
        end else if (bemf_valid && homing_active[bemf_gauge]) begin
            homing_sum <= sum_nxt;
        end
    end

endmodule

// [sim/gauge_status_readback_sva.sv]
// Port checker of the gauge status readback block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module gauge_status_readback_sva #(
    parameter int SAMPLE_W = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic supply_over,
    input wire gauge_pkg::gauge_in_type [1:0] gauge_in,
    input wire logic bemf_valid,
    input wire logic bemf_gauge,
    input wire logic signed [SAMPLE_W-1:0] bemf_sample,
    input wire logic [1:0] coil_disable,
    input wire logic [3:0] status_select,
    input wire logic [1:0] homing_active,
    input wire logic [14:0] homing_sum,
    input wire logic miso_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic quiet;
    assign quiet = !(gauge_in[0].homing_start || gauge_in[1].homing_start
        || gauge_in[0].homing_stop || gauge_in[1].homing_stop);
    a_over_disable: assert property (
        supply_over |=> coil_disable == 2'h3)
        else $error("no disable after overvoltage");
    a_disable_hold: assert property (
        coil_disable[1] && !gauge_in[1].reenable |=> coil_disable[1])
        else $error("disable dropped early");
    a_disable_cause: assert property (
        $rose(coil_disable[0])
        |-> $past(supply_over || gauge_in[0].overheat))
        else $error("disable without cause");
    a_reset_clear: assert property (
        $fell(sys_rst) |-> homing_sum == 15'h0000 && !homing_active)
        else $error("homing state not cleared");
    a_sum_hold: assert property (
        !homing_active && quiet |=> $stable(homing_sum))
        else $error("sum moved while idle");
    a_sum_integrate: assert property (
        bemf_valid && homing_active[bemf_gauge] && quiet
        |=> homing_sum == $past(homing_sum) + 15'($past(bemf_sample)))
        else $error("sum step wrong");
    a_oe_frame: assert property (
        $fell(cs_n) |-> ##[2:5] miso_oe)
        else $error("output not enabled");
    a_select_stable: assert property (
        cs_n [*6] |=> $stable(status_select))
        else $error("select changed between frames");
    c_frame: cover property ($fell(cs_n));
    c_over: cover property (supply_over);
    c_homing: cover property (bemf_valid && homing_active != 2'h0);
endmodule

bind gauge_status_readback gauge_status_readback_sva #(
    .SAMPLE_W(SAMPLE_W)
) i_gauge_status_readback_sva (
    .ref_clk, .sys_rst, .cs_n, .supply_over, .gauge_in, .bemf_valid,
    .bemf_gauge, .bemf_sample, .coil_disable, .status_select,
    .homing_active, .homing_sum, .miso_oe
);

// [sim/spi_host_model.sv]
// Host side serial master: mode 0 frames of up to 32 bits.
// Caller starts a frame just after a core clock edge.
`timescale 1ns/1ps
module spi_host_model (
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    // Keeps the first 16 bits seen; clock idles low outside frames
    task automatic xfer(input logic [31:0] tx, input int n,
            output logic [15:0] rx);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = tx[i];
            #32 sclk = 1'b1;
            if (i >= n - 16)
                rx = {rx[14:0], miso};
            #32 sclk = 1'b0;
        end
        #32 cs_n = 1'b1;
        // Released line shows the inverse of its last bit
        mosi = ~mosi;
        #64;
    endtask
endmodule

// [sim/gauge_status_readback_tb.sv]
// Testbench of the gauge status readback block.
// Host model drives the serial pins; bench drives the status inputs.
`timescale 1ns/1ps
module gauge_status_readback_tb;
    typedef struct {
        string nm;
        logic [15:0] v;
    } note_type;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_over = 1'b0;
    logic supply_under = 1'b0;
    logic clk_trim_bad = 1'b0;
    gauge_pkg::gauge_in_type [1:0] gauge_in = '0;
    logic bemf_valid = 1'b0;
    logic bemf_gauge = 1'b1;
    logic signed [7:0] bemf_sample = 8'h00;
    logic cs_n, sclk, mosi, miso, miso_oe;
    logic [1:0] coil_disable, homing_active, ze, ot;
    logic [3:0] status_select;
    logic [14:0] homing_sum, exp_sum;
    logic [15:0] obs, rx;
    int seed = 32'hee54;
    int mismatches = 0;
    int check_count = 0;
    note_type exp_q[$];
    event obs_ev;

    always #2 ref_clk = ~ref_clk;

    gauge_status_readback i_gauge_status_readback (
        .ref_clk, .sys_rst, .cs_n, .sclk, .mosi, .miso, .miso_oe,
        .supply_over, .supply_under, .clk_trim_bad, .gauge_in,
        .bemf_valid, .bemf_gauge, .bemf_sample, .coil_disable,
        .status_select, .homing_active, .homing_sum
    );
    spi_host_model i_spi_host_model (.cs_n, .sclk, .mosi, .miso);

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic see(input string nm, input logic [15:0] e,
            input logic [15:0] o);
        exp_q.push_back('{nm, e});
        obs = o;
        -> obs_ev;
        #0;
    endtask
    // Frame that also selects the next status word when its length is a multiple of 16
    task automatic rd(input string nm, input logic [15:0] e,
            input logic [3:0] sel, input int n = 16);
        i_spi_host_model.xfer({2{4'h0, sel, 8'h00}}, n, rx);
        step(4);
        if (n % 16 == 0)
            see(nm, e, rx);
        else
            see(nm, e, {12'h000, status_select});
    endtask
    function automatic logic [15:0] dw(input logic [9:0] lo);
        return {2'b00, ze, ot, lo};
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(obs_ev) begin
        note_type n;
        n = exp_q.pop_front();
        check_count++;
        if (obs !== n.v) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", n.nm, n.v, obs);
        end
    end

    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial begin
        step(10);
        sys_rst = 1'b0;
        ze = 2'($random(seed));
        ot = 2'($random(seed));
        for (int g = 0; g < 2; g++) begin
            gauge_in[g].zero_end = ze[g];
            gauge_in[g].off_target = ot[g];
        end
        step(3);
        see("reset", 16'h0000, {homing_sum,
            |{coil_disable, homing_active, status_select}});
        rd("dev word", dw(10'h000), 4'h0);
        $display("reset test done");
        {supply_over, supply_under, clk_trim_bad} = 3'h7;
        {gauge_in[1].pos_step, gauge_in[0].pos_step} = 2'h3;
        step(1);
        {supply_over, supply_under} = 2'h0;
        {gauge_in[1].pos_step, gauge_in[0].pos_step} = 2'h0;
        see("disable", 16'h0003, {14'h0000, coil_disable});
        rd("short frame", 16'h0000, 4'h8, 24);
        rd("faults", dw(10'h3f0), 4'h0);
        clk_trim_bad = 1'b0;
        rd("cleared", dw(10'h000), 4'h0);
        {gauge_in[1].reenable, gauge_in[0].reenable} = 2'h3;
        step(1);
        {gauge_in[1].reenable, gauge_in[0].reenable} = 2'h0;
        see("reenable", 16'h0000, {14'h0000, coil_disable});
        $display("supply test done");
        gauge_in[0].overheat = 1'b1;
        step(1);
        gauge_in[0].overheat = 1'b0;
        see("trip", 16'h0001, {14'h0000, coil_disable});
        rd("trip flag", dw(10'h001), 4'h0);
        rd("trip held", dw(10'h001), 4'h0);
        gauge_in[0].reenable = 1'b1;
        step(1);
        gauge_in[0].reenable = 1'b0;
        rd("trip gone", dw(10'h000), 4'h8);
        $display("thermal test done");
        gauge_in[1].homing_start = 1'b1;
        step(1);
        gauge_in[1].homing_start = 1'b0;
        exp_sum = 15'h0000;
        repeat (6) begin
            bemf_sample = {1'b0, 7'($random(seed))};
            exp_sum += 15'(bemf_sample);
            bemf_valid = 1'b1;
            step(1);
            bemf_valid = 1'b0;
            step(1);
        end
        see("homing", 16'h0002, {14'h0000, homing_active});
        see("sum", {1'b0, exp_sum}, {1'b0, homing_sum});
        rd("sum word", {1'b1, exp_sum}, 4'hb);
        gauge_in[1].homing_stop = 1'b1;
        step(1);
        gauge_in[1].homing_stop = 1'b0;
        bemf_valid = 1'b1;
        step(1);
        bemf_valid = 1'b0;
        rd("sum kept", {1'b0, exp_sum}, 4'h7);
        rd("dev again", dw(10'h000), 4'h0);
        $display("homing test done");
        end_of_test();
    end
endmodule
